// ---- pkg/jtag_sync_pkg.sv ----
package jtag_sync_pkg;
   // Probe pacing: system clocks per half period of the test clock
   localparam int HALF_PERIOD_CYCLES = 4;
   localparam int TIMEOUT_CYCLES = 256;
   localparam int IR_WIDTH = 4;
   localparam logic [3:0] IR_RESET_VALUE = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_IDCODE = 4'h1;
   // Arbitrary neutral identification value
   localparam logic [31:0] ID_VALUE = 32'h00000001;
   localparam int SYNC_STAGES = 2;
endpackage : jtag_sync_pkg

// ---- pkg/jtag_link_if.sv ----
`timescale 1ns/1ns
interface jtag_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic trst_n;
   logic returned_test_clock;
   modport target (input tck, input tms, input tdi, input trst_n, output tdo, output returned_test_clock);
   modport probe (output tck, output tms, output tdi, output trst_n, input tdo, input returned_test_clock);
endinterface : jtag_link_if

// ---- verilog/jtag_probe.sv ----
`timescale 1ns/1ns
module jtag_probe #(
   parameter int HALF_PERIOD = jtag_sync_pkg::HALF_PERIOD_CYCLES,
   parameter int TIMEOUT = jtag_sync_pkg::TIMEOUT_CYCLES
) (
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   jtag_link_if.probe LINK,
   input wire logic i_adaptive_en,
   input wire logic i_autodetect,
   input wire logic i_timeout_en,
   input wire logic i_trst_req,
   input wire logic i_bit_valid,
   input wire logic i_bit_tms,
   input wire logic i_bit_tdi,
   output logic o_bit_ready,
   output logic o_bit_done,
   output logic o_bit_tdo,
   output logic o_adaptive_active,
   output logic o_timeout,
   output logic o_tap_unknown
);
   initial begin
      if (HALF_PERIOD < 1 || TIMEOUT < 2 || TIMEOUT > 65535) $error("Bad probe parameters");
   end
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_LOW = 4'b0010,
      S_HIGH = 4'b0100,
      S_ERR = 4'b1000
   } pstate_t;
   pstate_t state_reg, state_next;
   logic [1:0] returned_test_clock_sync_reg;
   logic [1:0] tdo_sync_reg;
   logic [15:0] cnt_reg;
   logic tck_reg, tms_reg, tdi_reg, trst_n_reg;
   logic detected_reg;
   logic returned_test_clock_s, tdo_s;
   assign returned_test_clock_s = returned_test_clock_sync_reg[1];
   assign tdo_s = tdo_sync_reg[1];
   // R4 - adaptive only when chosen
   wire adaptive = i_adaptive_en | detected_reg;
   // R2 - wait for echo
   wire echo_ok = adaptive ? (returned_test_clock_s == tck_reg) : 1'b1;
   wire half_done = cnt_reg >= 16'(HALF_PERIOD - 1);
   // R5 - fixed unscaled timeout
   wire timed_out = i_timeout_en & adaptive & ~echo_ok & (cnt_reg >= 16'(TIMEOUT - 1));
   wire advance = half_done & echo_ok;
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: if (i_bit_valid & ~i_trst_req) state_next = S_LOW;
         S_LOW: if (timed_out) state_next = S_ERR; else if (advance) state_next = S_HIGH;
         S_HIGH: if (timed_out) state_next = S_ERR; else if (advance) state_next = S_IDLE;
         // R7 - reconnect via TAP reset
         S_ERR: if (i_trst_req) state_next = S_IDLE;
      endcase
   end
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_reg <= S_IDLE;
         returned_test_clock_sync_reg <= 2'h0;
         tdo_sync_reg <= 2'h0;
         cnt_reg <= 16'h0000;
         tck_reg <= 1'b0;
         tms_reg <= 1'b1;
         tdi_reg <= 1'b1;
         trst_n_reg <= 1'b0;
         detected_reg <= 1'b0;
         o_bit_ready <= 1'b0;
         o_bit_done <= 1'b0;
         o_bit_tdo <= 1'b0;
         o_adaptive_active <= 1'b0;
         o_timeout <= 1'b0;
         o_tap_unknown <= 1'b0;
      end else begin
         returned_test_clock_sync_reg <= {returned_test_clock_sync_reg[0], LINK.returned_test_clock};
         tdo_sync_reg <= {tdo_sync_reg[0], LINK.tdo};
         state_reg <= state_next;
         trst_n_reg <= ~i_trst_req;
         o_bit_done <= 1'b0;
         o_timeout <= 1'b0;
         o_adaptive_active <= adaptive;
         o_bit_ready <= (state_next == S_IDLE) & ~i_trst_req;
         if (state_reg != state_next) cnt_reg <= 16'h0000;
         else if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
         // R3 - echo seen enables adaptive
         // Echo arrives after tck may already have fallen, so any echo pulse counts
         if (i_autodetect & returned_test_clock_s) detected_reg <= 1'b1;
         else if (~i_autodetect) detected_reg <= 1'b0;
         if (state_reg == S_IDLE && state_next == S_LOW) begin
            tms_reg <= i_bit_tms;
            tdi_reg <= i_bit_tdi;
         end
         if (state_reg == S_LOW && state_next == S_HIGH) begin
            tck_reg <= 1'b1;
            o_bit_tdo <= tdo_s;
         end
         if (state_reg == S_HIGH && state_next == S_IDLE) begin
            tck_reg <= 1'b0;
            o_bit_done <= 1'b1;
         end
         // R6 - timeout flags unknown TAP
         if (state_next == S_ERR && state_reg != S_ERR) begin
            o_timeout <= 1'b1;
            o_tap_unknown <= 1'b1;
            tck_reg <= 1'b0;
         end
         if (i_trst_req) o_tap_unknown <= 1'b0;
      end
   end
   // R1 - drive the JTAG pins
   assign LINK.tck = tck_reg;
   assign LINK.tms = tms_reg;
   assign LINK.tdi = tdi_reg;
   assign LINK.trst_n = trst_n_reg;
endmodule : jtag_probe

// ---- verilog/jtag_target.sv ----
`timescale 1ns/1ns
// Overview of operation
// R1 - Five JTAG wires plus returned clock
// R2 - Probe waits for echo per edge
// R3 - Probe enables adaptive on seen echo
// R4 - Adaptive off unless needed, switchable
// R5 - Adaptive timeouts are fixed length
// R6 - Timeouts on by default, optional; the probe has them off unless i_timeout_en is high
// R7 - After timeout, reset TAP and reconnect
// R8 - All flops on one clock edge
// R9 - Test clock edges become enables
// R10 - Each strobe lasts one cycle
// R11 - Echo and data change on strobes
// R12 - Echo feedback paces the port
// R13 - Two stage test clock synchroniser
// R14 - Opposite edges optional, not used
// R15 - No test clock event ever missed
// R16 - TAP reset independent of system reset
// R17 - Sample on rise, launch on fall
module jtag_target #(
   parameter int STAGES = jtag_sync_pkg::SYNC_STAGES
) (
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   jtag_link_if.target LINK,
   output logic o_test_clock_rise_strobe,
   output logic o_test_clock_fall_strobe,
   output logic [3:0] o_instruction,
   output logic o_tap_reset_state,
   output logic o_capture_strobe,
   output logic o_update_strobe
);
   initial begin
      if (STAGES < 2 || STAGES > 4) $error("Bad synchroniser depth");
   end
   typedef enum logic [15:0] {
      T_RESET = 16'h0001, T_IDLE = 16'h0002, T_SEL_DR = 16'h0004, T_CAP_DR = 16'h0008,
      T_SH_DR = 16'h0010, T_EX1_DR = 16'h0020, T_PAU_DR = 16'h0040, T_EX2_DR = 16'h0080,
      T_UPD_DR = 16'h0100, T_SEL_IR = 16'h0200, T_CAP_IR = 16'h0400, T_SH_IR = 16'h0800,
      T_EX1_IR = 16'h1000, T_PAU_IR = 16'h2000, T_EX2_IR = 16'h4000, T_UPD_IR = 16'h8000
   } tap_t;
   tap_t tap_reg, tap_next;
   // R13 - cascaded synchroniser
   logic [STAGES-1:0] tck_sync_reg;
   logic [1:0] trst_sync_reg;
   logic tck_prev_reg, tms_reg_s, tdi_reg_s;
   logic [1:0] tms_sync_reg, tdi_sync_reg;
   logic returned_test_clock_reg, tdo_reg;
   logic [3:0] ir_reg, ir_sh_reg;
   logic [31:0] dr_sh_reg;
   logic tck_s, trst_act;
   // R8 - single rising edge everywhere
   // R14 - same edge kept for both stages
   assign tck_s = tck_sync_reg[STAGES-1];
   assign trst_act = ~trst_sync_reg[1];
   // R9 - edges become enables
   // R10 - one cycle per edge
   wire rise = tck_s & ~tck_prev_reg;
   wire fall = ~tck_s & tck_prev_reg;
   wire tms_s = tms_sync_reg[1];
   wire tdi_s = tdi_sync_reg[1];
   always_comb begin
      tap_next = tap_reg;
      unique case (tap_reg)
         T_RESET: tap_next = tms_s ? T_RESET : T_IDLE;
         T_IDLE: tap_next = tms_s ? T_SEL_DR : T_IDLE;
         T_SEL_DR: tap_next = tms_s ? T_SEL_IR : T_CAP_DR;
         T_CAP_DR: tap_next = tms_s ? T_EX1_DR : T_SH_DR;
         T_SH_DR: tap_next = tms_s ? T_EX1_DR : T_SH_DR;
         T_EX1_DR: tap_next = tms_s ? T_UPD_DR : T_PAU_DR;
         T_PAU_DR: tap_next = tms_s ? T_EX2_DR : T_PAU_DR;
         T_EX2_DR: tap_next = tms_s ? T_UPD_DR : T_SH_DR;
         T_UPD_DR: tap_next = tms_s ? T_SEL_DR : T_IDLE;
         T_SEL_IR: tap_next = tms_s ? T_RESET : T_CAP_IR;
         T_CAP_IR: tap_next = tms_s ? T_EX1_IR : T_SH_IR;
         T_SH_IR: tap_next = tms_s ? T_EX1_IR : T_SH_IR;
         T_EX1_IR: tap_next = tms_s ? T_UPD_IR : T_PAU_IR;
         T_PAU_IR: tap_next = tms_s ? T_EX2_IR : T_PAU_IR;
         T_EX2_IR: tap_next = tms_s ? T_UPD_IR : T_SH_IR;
         T_UPD_IR: tap_next = tms_s ? T_SEL_DR : T_IDLE;
      endcase
   end
   wire bypass = (ir_reg == jtag_sync_pkg::IR_BYPASS);
   wire dr_out = bypass ? dr_sh_reg[31] : dr_sh_reg[0];
   wire shift_out = (tap_reg == T_SH_IR) ? ir_sh_reg[0] : dr_out;
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tck_sync_reg <= '0;
         trst_sync_reg <= 2'h0;
         tms_sync_reg <= 2'h3;
         tdi_sync_reg <= 2'h3;
         tck_prev_reg <= 1'b0;
         returned_test_clock_reg <= 1'b0;
         tdo_reg <= 1'b0;
         o_test_clock_rise_strobe <= 1'b0;
         o_test_clock_fall_strobe <= 1'b0;
         o_capture_strobe <= 1'b0;
         o_update_strobe <= 1'b0;
      end else begin
         tck_sync_reg <= {tck_sync_reg[STAGES-2:0], LINK.tck};
         trst_sync_reg <= {trst_sync_reg[0], LINK.trst_n};
         tms_sync_reg <= {tms_sync_reg[0], LINK.tms};
         tdi_sync_reg <= {tdi_sync_reg[0], LINK.tdi};
         // R15 - level compare never drops events
         tck_prev_reg <= tck_s;
         o_test_clock_rise_strobe <= rise;
         o_test_clock_fall_strobe <= fall;
         o_capture_strobe <= rise & ~trst_act & (tap_reg == T_CAP_DR);
         o_update_strobe <= rise & ~trst_act & (tap_reg == T_UPD_DR);
         // R11 - echo follows strobes only
         // R12 - echo paces next edge
         if (rise) returned_test_clock_reg <= 1'b1;
         else if (fall) returned_test_clock_reg <= 1'b0;
         // R17 - launch data on fall
         if (fall) tdo_reg <= shift_out;
      end
   end
   // R16 - TAP reset separate from system
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tap_reg <= T_RESET;
         ir_reg <= jtag_sync_pkg::IR_RESET_VALUE;
         ir_sh_reg <= 4'h0;
         dr_sh_reg <= 32'h00000000;
      end else if (trst_act) begin
         tap_reg <= T_RESET;
         ir_reg <= jtag_sync_pkg::IR_RESET_VALUE;
      end else if (rise) begin
         // R17 - sample on rise
         tap_reg <= tap_next;
         unique case (tap_reg)
            T_RESET: ir_reg <= jtag_sync_pkg::IR_RESET_VALUE;
            T_CAP_IR: ir_sh_reg <= 4'h1;
            T_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
            T_UPD_IR: ir_reg <= ir_sh_reg;
            T_CAP_DR: dr_sh_reg <= bypass ? 32'h00000000 : jtag_sync_pkg::ID_VALUE;
            T_SH_DR: dr_sh_reg <= bypass ? {tdi_s, 31'h00000000} : {tdi_s, dr_sh_reg[31:1]};
            default: ;
         endcase
      end
   end
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         o_instruction <= jtag_sync_pkg::IR_RESET_VALUE;
         o_tap_reset_state <= 1'b1;
      end else begin
         o_instruction <= ir_reg;
         o_tap_reset_state <= (tap_reg == T_RESET);
      end
   end
   assign LINK.returned_test_clock = returned_test_clock_reg;
   assign LINK.tdo = tdo_reg;
endmodule : jtag_target

// ---- test/jtag_adaptive_clock_sync_monitor.sv ----
`timescale 1ns/1ns
module jtag_adaptive_clock_sync_monitor (
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic trst_n,
   input wire logic returned_test_clock
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_ARST_N);
   // Echo trails the pin by the synchroniser delay
   sequence s_echo_up;
      ##[2:4] $rose(returned_test_clock);
   endsequence
   sequence s_echo_down;
      ##[2:4] $fell(returned_test_clock);
   endsequence
   a_echo_rise_bound: assert property ($rose(tck) |-> s_echo_up)
      else $error("echo missing after test clock rise");
   a_echo_fall_bound: assert property ($fell(tck) |-> s_echo_down)
      else $error("echo missing after test clock fall");
   a_echo_rise_cause: assert property ($rose(returned_test_clock) |-> $past(tck, 3))
      else $error("echo rose without a test clock rise");
   a_echo_fall_cause: assert property ($fell(returned_test_clock) |-> !$past(tck, 3))
      else $error("echo fell without a test clock fall");
   a_data_on_fall: assert property (trst_n && $changed(tdo) |-> $fell(returned_test_clock))
      else $error("data changed away from a fall strobe");
   a_pace_rise: assert property ($rose(tck) |-> !returned_test_clock)
      else $error("test clock rose before echo fell");
   a_pace_fall: assert property ($fell(tck) |-> returned_test_clock)
      else $error("test clock fell before echo rose");
   a_bit_setup: assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
      else $error("mode or data moved while test clock high");
endmodule : jtag_adaptive_clock_sync_monitor

// ---- test/jtag_adaptive_clock_sync_bench.sv ----
`timescale 1ns/1ns
module jtag_adaptive_clock_sync_bench;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic ad = 1'b0, au = 1'b0, te = 1'b0, tr = 1'b0, vl = 1'b0, ms = 1'b1, di = 1'b1;
   logic te_b = 1'b0, tr_b = 1'b0, vl_b = 1'b0;
   logic rdy, done, tdo, act, tmo, unk, rdy_b, tmo_b, unk_b, rs, fs, trs, cs, us;
   int nc = 0, nu = 0;
   logic [3:0] ir;
   logic [31:0] dout;
   int err_count = 0, n_checks = 0, nr = 0, nf = 0, n = 0;
   jtag_link_if lk ();
   jtag_link_if lb ();
   // Dead far end: echo never returns
   assign lb.tdo = 1'b0;
   assign lb.returned_test_clock = 1'b0;
   always #20 mclk = ~mclk;
   jtag_probe i_jtag_probe (.I_MCLK(mclk), .I_ARST_N(arst_n), .LINK(lk), .i_adaptive_en(ad), .i_autodetect(au),
      .i_timeout_en(te), .i_trst_req(tr), .i_bit_valid(vl), .i_bit_tms(ms), .i_bit_tdi(di), .o_bit_ready(rdy),
      .o_bit_done(done), .o_bit_tdo(tdo), .o_adaptive_active(act), .o_timeout(tmo), .o_tap_unknown(unk));
   jtag_probe #(.TIMEOUT(16)) i_jtag_probe_b (.I_MCLK(mclk), .I_ARST_N(arst_n), .LINK(lb), .i_adaptive_en(1'b1),
      .i_autodetect(1'b0), .i_timeout_en(te_b), .i_trst_req(tr_b), .i_bit_valid(vl_b), .i_bit_tms(1'b1),
      .i_bit_tdi(1'b1), .o_bit_ready(rdy_b), .o_bit_done(), .o_bit_tdo(), .o_adaptive_active(), .o_timeout(tmo_b),
      .o_tap_unknown(unk_b));
   jtag_target i_jtag_target (.I_MCLK(mclk), .I_ARST_N(arst_n), .LINK(lk), .o_test_clock_rise_strobe(rs),
      .o_test_clock_fall_strobe(fs), .o_instruction(ir), .o_tap_reset_state(trs), .o_capture_strobe(cs),
      .o_update_strobe(us));
   jtag_adaptive_clock_sync_monitor i_jtag_adaptive_clock_sync_monitor (.I_MCLK(mclk), .I_ARST_N(arst_n),
      .tck(lk.tck), .tms(lk.tms), .tdi(lk.tdi), .tdo(lk.tdo), .trst_n(lk.trst_n),
      .returned_test_clock(lk.returned_test_clock));
   // Counting high cycles also catches stretched strobes
   always @(negedge mclk) begin
      if (rs === 1'b1) nr++;
      if (fs === 1'b1) nf++;
      if (cs === 1'b1) nc++;
      if (us === 1'b1) nu++;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic tick();
      @(negedge mclk);
      if (++n > 3000) begin
         err_count++;
         $display("mismatch wait_bound expected 3000 seen %0d", n);
         final_report();
      end
   endtask : tick
   task automatic send(input logic m, input logic d, output logic o);
      n = 0;
      while (rdy !== 1'b1) tick();
      @(posedge mclk);
      vl <= 1'b1;
      ms <= m;
      di <= d;
      @(posedge mclk);
      vl <= 1'b0;
      do tick(); while (done !== 1'b1);
      o = tdo;
   endtask : send
   task automatic scan(input logic irp, input int len, input logic [31:0] din);
      logic o;
      dout = '0;
      send(1'b0, 1'b1, o);
      send(1'b1, 1'b1, o);
      if (irp) send(1'b1, 1'b1, o);
      send(1'b0, 1'b1, o);
      send(1'b0, 1'b1, o);
      for (int i = 0; i < len; i++) begin
         send(i == len - 1, din[i], o);
         dout[i] = o;
      end
      send(1'b1, 1'b1, o);
      send(1'b0, 1'b1, o);
   endtask : scan
   task automatic t_strobes();
      logic o;
      nr = 0;
      nf = 0;
      repeat (8) send(1'b1, 1'b1, o);
      repeat (8) @(negedge mclk);
      chk("rise_strobes", 32'h8, 32'(nr));
      chk("fall_strobes", 32'h8, 32'(nf));
   endtask : t_strobes
   task automatic t_tap();
      @(posedge mclk);
      tr <= 1'b1;
      ad <= 1'b1;
      repeat (10) @(negedge mclk);
      chk("tap_reset", 32'h1, 32'(trs));
      @(posedge mclk);
      tr <= 1'b0;
      nc = 0;
      nu = 0;
      scan(1'b0, 32, 32'h0);
      chk("id", jtag_sync_pkg::ID_VALUE, dout);
      chk("capture_strobes", 32'h1, 32'(nc));
      chk("update_strobes", 32'h1, 32'(nu));
      scan(1'b1, 4, 32'(jtag_sync_pkg::IR_BYPASS));
      chk("instruction", 32'(jtag_sync_pkg::IR_BYPASS), 32'(ir));
   endtask : t_tap
   task automatic t_detect();
      logic o;
      @(posedge mclk);
      ad <= 1'b0;
      au <= 1'b1;
      send(1'b1, 1'b1, o);
      // Echo, its synchroniser and the flag register trail the bit
      repeat (4) @(negedge mclk);
      chk("autodetect", 32'h1, 32'(act));
      @(posedge mclk);
      au <= 1'b0;
      repeat (3) @(negedge mclk);
      chk("adaptive_off", 32'h0, 32'(act));
   endtask : t_detect
   task automatic wait_b(input int lim);
      n = 0;
      while (tmo_b !== 1'b1 && n < lim) tick();
   endtask : wait_b
   task automatic t_timeout();
      while (rdy_b !== 1'b1) tick();
      @(posedge mclk);
      vl_b <= 1'b1;
      @(posedge mclk);
      vl_b <= 1'b0;
      wait_b(60);
      chk("no_timeout", 32'h0, 32'(tmo_b));
      @(posedge mclk);
      te_b <= 1'b1;
      wait_b(60);
      chk("timeout", 32'h1, 32'(tmo_b));
      @(negedge mclk);
      chk("tap_unknown", 32'h1, 32'(unk_b));
      chk("refused", 32'h0, 32'(rdy_b));
      @(posedge mclk);
      tr_b <= 1'b1;
      repeat (4) @(posedge mclk);
      tr_b <= 1'b0;
      repeat (2) @(negedge mclk);
      chk("tap_known", 32'h0, 32'(unk_b));
      while (rdy_b !== 1'b1) tick();
      @(posedge mclk);
      vl_b <= 1'b1;
      @(posedge mclk);
      vl_b <= 1'b0;
      wait_b(60);
      chk("fixed_length", 32'h1, 32'(n >= 16 && n <= 16 + 2 * jtag_sync_pkg::HALF_PERIOD_CYCLES + 8));
   endtask : t_timeout
   initial begin
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(negedge mclk);
      chk("reset_state", 32'h1, 32'(trs));
      chk("reset_ir", 32'(jtag_sync_pkg::IR_RESET_VALUE), 32'(ir));
      chk("adaptive_idle", 32'h0, 32'(act));
      t_strobes();
      t_tap();
      t_detect();
      t_timeout();
      final_report();
   end
endmodule : jtag_adaptive_clock_sync_bench
